//--- clock_freeze_params.svh
`ifndef CLOCK_FREEZE_PARAMS_SVH
`define CLOCK_FREEZE_PARAMS_SVH
`define FRZ_NUM_BITS        12
`define FRZ_CNT_W           4
`define FRZ_ENABLE_RESET    12'hfff
`define FRZ_BANK_A_LSB      0
`define FRZ_BANK_B_LSB      4
`define FRZ_BANK_C_LSB      8
`define FRZ_SYNC_BIT        11
`define FRZ_LAST_CNT        4'hb
`endif

//--- clock_freeze_pkg.sv
package clock_freeze_pkg;
  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_DATA = 1'b1
  } rx_state_t;
endpackage

//--- clock_output_freeze.sv
// Overview of operation
// [RULE_01] A twelve-bit serially loaded freeze-enable register gates twelve of fourteen outputs.
// [RULE_02] Bank C first output and feedback output are never stopped.
// [RULE_03] An enable bit of zero stops its output, held low.
// [RULE_04] An enable bit of one lets its output run normally.
// [RULE_05] A newly frozen output finishes its high phase, then stays low.
// [RULE_06] A newly unfrozen output restarts only while its clock is low.
// [RULE_07] The controller sends a low start bit then twelve NRZ bits.
// [RULE_08] The controller holds each bit one freeze-clock period, valid at rising edges.
// [RULE_09] Data is sampled on each freeze-clock rising edge; start then twelve bits.
// [RULE_10] Bits 0-3 drive bank A outputs 0-3, bits 4-7 bank B outputs 0-3.
// [RULE_11] Bits 8-10 drive bank C outputs 1-3; bit 11 drives the sync output.
// [RULE_12] New settings apply together after bit twelve; idle line is high.
// [RULE_13] After reset all enable bits are one so all outputs run.
`timescale 1ns/100ps
`include "clock_freeze_params.svh"

module clock_output_freeze
  import clock_freeze_pkg::*;
#(
  parameter int NUM_BITS = `FRZ_NUM_BITS
) (
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                freezeClk,
  input  wire logic                freezeData,
  input  wire logic [3:0]          bankAClkIn,
  input  wire logic [3:0]          bankBClkIn,
  input  wire logic [3:0]          bankCClkIn,
  input  wire logic                syncClkIn,
  input  wire logic                feedbackClkIn,
  output logic      [3:0]          bank_a_clock_outputs,
  output logic      [3:0]          bank_b_clock_outputs,
  output logic                     bank_c_first_output,
  output logic      [2:0]          bank_c_freezable_outputs,
  output logic                     sync_pulse_output,
  output logic                     pll_feedback_output,
  output logic      [NUM_BITS-1:0] freezeEnableView
);

  // Link domain: serial receiver clocked by the freeze clock itself.
  // A frame cut short has no abort path; it simply stays pending until complete.
  // The start bit is taken only in idle, so a high line between frames is ignored.
  rx_state_t             rxState_reg;
  rx_state_t             rxState_next;
  logic [`FRZ_CNT_W-1:0] bitCnt_reg;
  logic [`FRZ_CNT_W-1:0] bitCnt_next;

  logic [NUM_BITS-1:0]   shift_reg;
  logic [NUM_BITS-1:0]   shift_next;
  logic [NUM_BITS-1:0]   held_reg;
  logic [NUM_BITS-1:0]   held_next;
  logic                  toggle_reg;
  logic                  toggle_next;

  // Frame control: a low level in idle is a start bit, then twelve data bits follow.
  always_comb begin
    rxState_next = rxState_reg;
    bitCnt_next  = bitCnt_reg;
    case (rxState_reg)
      RX_IDLE: begin
        if (!freezeData) begin // RULE_09
          rxState_next = RX_DATA;
          bitCnt_next  = '0;
        end
      end
      RX_DATA: begin
        bitCnt_next = bitCnt_reg + 4'h1;
        if (bitCnt_reg == `FRZ_LAST_CNT) begin
          rxState_next = RX_IDLE;
        end
      end
      default: begin
        rxState_next = RX_IDLE;
        bitCnt_next  = '0;
      end
    endcase
  end

  // Frame data: the last bit goes straight into the held word, so the word and the
  // toggle change on the same edge and the core side never sees a half-built word.
  always_comb begin
    shift_next  = shift_reg;
    held_next   = held_reg;
    toggle_next = toggle_reg;
    case (rxState_reg)
      RX_IDLE: begin
        shift_next = shift_reg;
      end
      RX_DATA: begin
        // First received bit lands in bit 0, so bit order matches output order.
        shift_next = {freezeData, shift_reg[NUM_BITS-1:1]}; // RULE_09
        if (bitCnt_reg == `FRZ_LAST_CNT) begin
          held_next   = {freezeData, shift_reg[NUM_BITS-1:1]}; // RULE_12
          toggle_next = ~toggle_reg;
        end
      end
      default: begin
        shift_next = shift_reg;
      end
    endcase
  end

  // Receiver registers, one group to a process.
  always_ff @(posedge freezeClk or negedge rst_b) begin
    if (!rst_b) begin
      rxState_reg <= RX_IDLE;
    end else begin
      rxState_reg <= rxState_next;
    end
  end

  always_ff @(posedge freezeClk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_reg <= '0;
    end else begin
      bitCnt_reg <= bitCnt_next;
    end
  end

  // The shift register resets to all ones, the same as the enable word.
  always_ff @(posedge freezeClk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= `FRZ_ENABLE_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge freezeClk or negedge rst_b) begin
    if (!rst_b) begin
      held_reg <= `FRZ_ENABLE_RESET; // RULE_13
    end else begin
      held_reg <= held_next;
    end
  end

  always_ff @(posedge freezeClk or negedge rst_b) begin
    if (!rst_b) begin
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= toggle_next;
    end
  end

  // Core domain: the held word is stable for a whole frame after each toggle,
  // so it is safe to copy once the synchronised toggle shows a change.
  // Only the second synchroniser stage is read by logic; the first may be metastable.
  logic                tglSync1_reg;
  logic                tglSync2_reg;
  logic                tglSeen_reg;
  logic [NUM_BITS-1:0] enable_reg;
  logic [NUM_BITS-1:0] enable_next;

  // The copy happens once per toggle change; tglSeen remembers the last one seen.
  always_comb begin
    enable_next = enable_reg;
    if (tglSync2_reg != tglSeen_reg) begin
      enable_next = held_reg; // RULE_01 RULE_12
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tglSync1_reg <= 1'b0;
    end else begin
      tglSync1_reg <= toggle_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tglSync2_reg <= 1'b0;
    end else begin
      tglSync2_reg <= tglSync1_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tglSeen_reg <= 1'b0;
    end else begin
      tglSeen_reg <= tglSync2_reg;
    end
  end

  // The reset value lets every output run before any frame has arrived.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= `FRZ_ENABLE_RESET; // RULE_13
    end else begin
      enable_reg <= enable_next;
    end
  end

  // Output gating: gate state changes only while the source clock is low,
  // which prevents both truncated high phases and runt pulses.
  // The cost is one core cycle of latency on every output, frozen or not.
  logic [NUM_BITS-1:0] srcClk;
  logic [NUM_BITS-1:0] gate_reg;
  logic [NUM_BITS-1:0] gate_next;
  logic [NUM_BITS-1:0] out_reg;
  logic [NUM_BITS-1:0] out_next;
  logic                fixedOut_reg;
  logic                fixedOut_next;
  logic                fbOut_reg;
  logic                fbOut_next;

  // Bank C output zero is not freezable and takes no enable bit.
  always_comb begin
    srcClk[`FRZ_BANK_A_LSB + 0] = bankAClkIn[0]; // RULE_10
    srcClk[`FRZ_BANK_A_LSB + 1] = bankAClkIn[1]; // RULE_10
    srcClk[`FRZ_BANK_A_LSB + 2] = bankAClkIn[2]; // RULE_10
    srcClk[`FRZ_BANK_A_LSB + 3] = bankAClkIn[3]; // RULE_10
    srcClk[`FRZ_BANK_B_LSB + 0] = bankBClkIn[0]; // RULE_10
    srcClk[`FRZ_BANK_B_LSB + 1] = bankBClkIn[1]; // RULE_10
    srcClk[`FRZ_BANK_B_LSB + 2] = bankBClkIn[2]; // RULE_10
    srcClk[`FRZ_BANK_B_LSB + 3] = bankBClkIn[3]; // RULE_10
    srcClk[`FRZ_BANK_C_LSB + 0] = bankCClkIn[1]; // RULE_11
    srcClk[`FRZ_BANK_C_LSB + 1] = bankCClkIn[2]; // RULE_11
    srcClk[`FRZ_BANK_C_LSB + 2] = bankCClkIn[3]; // RULE_11
    srcClk[`FRZ_SYNC_BIT]       = syncClkIn; // RULE_11
  end

  // Gating is per bit; each source clock is judged on its own low phase.
  genvar g;
  generate
    for (g = 0; g < NUM_BITS; g++) begin : gen_gate
      always_comb begin
        gate_next[g] = gate_reg[g];
        if (!srcClk[g]) begin
          gate_next[g] = enable_reg[g]; // RULE_03 RULE_04 RULE_05 RULE_06
        end
      end

      always_comb begin
        out_next[g] = srcClk[g] & gate_reg[g]; // RULE_05
      end
    end
  endgenerate

  // These two outputs feed the loop and have no enable bit at all, so a bad
  // frame can never stop the loop from locking.
  always_comb begin
    fixedOut_next = bankCClkIn[0]; // RULE_02
    fbOut_next    = feedbackClkIn; // RULE_02
  end

  // Gates reset open, matching the enable word, so outputs run straight after reset.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_reg <= `FRZ_ENABLE_RESET;
    end else begin
      gate_reg <= gate_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fixedOut_reg <= 1'b0;
    end else begin
      fixedOut_reg <= fixedOut_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fbOut_reg <= 1'b0;
    end else begin
      fbOut_reg <= fbOut_next;
    end
  end

  // Bit positions of the enable word follow the order in which bits arrive.
  // Every output below comes from a register, not from gating logic.
  always_comb begin
    bank_a_clock_outputs[0]     = out_reg[`FRZ_BANK_A_LSB + 0]; // RULE_10
    bank_a_clock_outputs[1]     = out_reg[`FRZ_BANK_A_LSB + 1]; // RULE_10
    bank_a_clock_outputs[2]     = out_reg[`FRZ_BANK_A_LSB + 2]; // RULE_10
    bank_a_clock_outputs[3]     = out_reg[`FRZ_BANK_A_LSB + 3]; // RULE_10
    bank_b_clock_outputs[0]     = out_reg[`FRZ_BANK_B_LSB + 0]; // RULE_10
    bank_b_clock_outputs[1]     = out_reg[`FRZ_BANK_B_LSB + 1]; // RULE_10
    bank_b_clock_outputs[2]     = out_reg[`FRZ_BANK_B_LSB + 2]; // RULE_10
    bank_b_clock_outputs[3]     = out_reg[`FRZ_BANK_B_LSB + 3]; // RULE_10
    bank_c_freezable_outputs[0] = out_reg[`FRZ_BANK_C_LSB + 0]; // RULE_11
    bank_c_freezable_outputs[1] = out_reg[`FRZ_BANK_C_LSB + 1]; // RULE_11
    bank_c_freezable_outputs[2] = out_reg[`FRZ_BANK_C_LSB + 2]; // RULE_11
    sync_pulse_output           = out_reg[`FRZ_SYNC_BIT]; // RULE_11
    bank_c_first_output         = fixedOut_reg;
    pll_feedback_output         = fbOut_reg;
    freezeEnableView            = enable_reg;
  end

endmodule // clock_output_freeze

//--- clock_output_freeze_asserts.sv
`timescale 1ns/100ps
module clock_output_freeze_asserts #(parameter int NUM_BITS = 12) (
  input wire logic                core_clk,
  input wire logic                rst_b,
  input wire logic                syncClkIn,
  input wire logic                feedbackClkIn,
  input wire logic                bank_c_first_output,
  input wire logic                sync_pulse_output,
  input wire logic                pll_feedback_output,
  input wire logic [3:0]          bankAClkIn,
  input wire logic [3:0]          bankBClkIn,
  input wire logic [3:0]          bankCClkIn,
  input wire logic [3:0]          bank_a_clock_outputs,
  input wire logic [3:0]          bank_b_clock_outputs,
  input wire logic [2:0]          bank_c_freezable_outputs,
  input wire logic [NUM_BITS-1:0] freezeEnableView
);
  wire [11:0] g = {sync_pulse_output, bank_c_freezable_outputs, bank_b_clock_outputs,
                   bank_a_clock_outputs};
  wire [11:0] s = {syncClkIn, bankCClkIn[3:1], bankBClkIn, bankAClkIn};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_fb_follow: assert property (pll_feedback_output == $past(feedbackClkIn))
    else $error("feedback lag");
  chk_c0_follow: assert property (bank_c_first_output == $past(bankCClkIn[0]))
    else $error("c0 lag");
  chk_no_runt: assert property ((g & ~$past(g) & ~($past(s) & ~$past(s, 2))) == 12'h000)
    else $error("runt rise");
  chk_no_cut: assert property (($past(g) & ~g & $past(s)) == 12'h000)
    else $error("high cut");
  chk_gated_src: assert property ((g & ~$past(s)) == 12'h000)
    else $error("high off src");
  chk_frozen_low: assert property ($stable(freezeEnableView)[*4] |->
    (g & ~freezeEnableView[11:0] & ~$past(g)) == 12'h000) else $error("frozen rose");
  chk_reset_all_on: assert property ($rose(rst_b) |-> freezeEnableView == 12'hfff)
    else $error("reset word");
  chk_word_hold: assert property ($changed(freezeEnableView) |=>
    $stable(freezeEnableView)[*7]) else $error("word unstable");
endmodule // clock_output_freeze_asserts
bind clock_output_freeze clock_output_freeze_asserts #(.NUM_BITS(NUM_BITS))
  clock_output_freeze_asserts_inst (.*);

//--- freeze_ctrl_model.sv
`timescale 1ns/100ps
module freeze_ctrl_model (
  input  wire logic        freezeClk,
  input  wire logic        go,
  input  wire logic [11:0] word,
  output logic             freezeData,
  output logic             busy
);
  logic [13:0] sh = 14'h3fff;
  logic [3:0]  n  = 4'h0;
  initial freezeData = 1'b1;
  assign busy = (n != 4'h0);
  // Bits move just after the edge, so each one is settled a whole period at the sampling edge.
  always @(posedge freezeClk) begin
    if (busy) begin
      freezeData <= sh[0];
      sh <= {1'b1, sh[13:1]};
      n <= n - 4'h1;
    end else if (go) begin
      sh <= {1'b1, word, 1'b0};
      n <= 4'he;
    end
  end
endmodule // freeze_ctrl_model

//--- test_clock_output_freeze.sv
`timescale 1ns/100ps
module test_clock_output_freeze;
  logic        core_clk = 1'b0, freezeClk = 1'b0, rst_b = 1'b0, go = 1'b0, busy, freezeData;
  logic [4:0]  cnt = 5'h00;
  logic [13:0] src = 14'h0000, o, sp;
  logic [11:0] w, word = 12'h000, lastView = 12'hfff, pw = 12'hfff, freezeEnableView;
  logic [11:0] q[$];
  int          fail_count = 0, comparisons = 0, k;
  always #5 core_clk = ~core_clk;
  always #3 freezeClk = ~freezeClk;
  always @(posedge core_clk) if (rst_b) begin
    cnt <= cnt + 5'h01;
    src <= {cnt[4:2], cnt[4:2], cnt[4:2], cnt[4:2], cnt[3:2]};
  end
  clock_output_freeze #(.NUM_BITS(12)) clock_output_freeze_inst (.core_clk, .rst_b, .freezeClk,
    .freezeData, .bankAClkIn(src[3:0]), .bankBClkIn(src[7:4]), .bankCClkIn(src[11:8]),
    .syncClkIn(src[12]), .feedbackClkIn(src[13]), .bank_a_clock_outputs(o[3:0]),
    .bank_b_clock_outputs(o[7:4]), .bank_c_first_output(o[8]), .bank_c_freezable_outputs(o[11:9]),
    .sync_pulse_output(o[12]), .pll_feedback_output(o[13]), .freezeEnableView);
  freeze_ctrl_model freeze_ctrl_model_inst (.freezeClk, .go, .word, .freezeData, .busy);
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic waitBusy(input logic lvl);
    k = 0;
    while (busy !== lvl && k < 300) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 300) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  always @(negedge core_clk) if (rst_b && freezeEnableView !== lastView) begin
    lastView = freezeEnableView;
    check({2'b00, freezeEnableView}, {2'b00, q.pop_front()});
  end
  initial begin
    w = $urandom(32'h38a7);
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    check({2'b00, freezeEnableView}, 14'h0fff);
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 12'h000 : (i == 7) ? 12'hfff : 12'($urandom);
      if (w != pw) q.push_back(w);
      pw = w;
      @(posedge core_clk);
      word <= w;
      go <= 1'b1;
      waitBusy(1'b1);
      go <= 1'b0;
      waitBusy(1'b0);
      repeat (40) @(posedge core_clk);
      @(negedge core_clk);
      sp = src;
      repeat (16) begin
        @(negedge core_clk);
        check(o, sp & {1'b1, w[11:8], 1'b1, w[7:0]});
        sp = src;
      end
      $display("frame %0d done", i);
    end
    report_and_stop;
  end
endmodule // test_clock_output_freeze
